// ==== rtl/dsa_debug_ctrl.v ====
/*
 Debug state controller: data-bus scan chain, debug-speed stepping,
 system-speed access from debug state, exit back to the memory clock,
 debug acknowledge and PC advance reporting.
 Assumes the scan clock and TAP state levels arrive from another clock
 domain and that the core and memory controller share CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dsa_defines.vh"

// Function
// - Any mode change allowed in debug state
// - Thirty-three scan clocks per core clock
// - Flag high on prior word means system speed
// - Bypass resyncs, runs access, returns to debug
// - After access acknowledge high, debug clock selected
// - Request low after resync; grant may stall
// - Return from access reports flag high
// - Branch after flagged word exits debug
// - Acknowledge high throughout debug state
// - Entry flushes the instruction pipeline
// - Final access after rise, refetch after fall
// - Acknowledge may drop unless forced high
// - Entry advances PC sixteen, steps four bytes
// - Chain shifts most significant bit first
// - Store multiple data captured from data bus
// - First capture reports breakpoint or watchpoint
// - Acknowledge rises before debug clock switch on entry
module dsa_debug_ctrl (
   input  wire                    CLOCK,
   input  wire                    RST_B,
   input  wire                    SCAN_CLK,
   input  wire                    SCAN_DI,
   input  wire                    TAP_SHIFT,
   input  wire                    TAP_CAPTURE,
   input  wire                    TAP_RUN_IDLE,
   input  wire                    TAP_BYPASS,
   input  wire                    BREAKPOINT_HIT,
   input  wire                    WATCHPOINT_HIT,
   input  wire                    BREAKPOINT_INPUT_BIT,
   input  wire                    FORCE_ACK_HIGH,
   input  wire                    CORE_MREQ_N,
   input  wire [`DSA_DATA_W-1:0]  CORE_DATA,
   input  wire                    MEM_GRANT,
   output reg                     SCAN_DO,
   output reg                     SCAN_DERIVED_CORE_CLOCK,
   output reg  [`DSA_DATA_W-1:0]  DEBUG_INSTR,
   output reg                     SYS_SPEED_EXEC,
   output reg                     PIPE_FLUSH,
   output reg                     PC_ADVANCE,
   output reg  [`DSA_PC_W-1:0]    PC_ADVANCE_BYTES,
   output reg                     MODE_CHANGE_ANY,
   output reg                     CLOCK_SELECT_DEBUG,
   output reg                     DEBUG_STATE_ACKNOWLEDGE,
   output reg                     MEMORY_REQUEST_N
);

   localparam [2:0] ST_RUN    = 3'h0;
   localparam [2:0] ST_ENTER  = 3'h1;
   localparam [2:0] ST_DEBUG  = 3'h2;
   localparam [2:0] ST_RESYNC = 3'h3;
   localparam [2:0] ST_SYSACC = 3'h4;
   localparam [2:0] ST_RETURN = 3'h5;
   localparam [2:0] ST_EXIT   = 3'h6;

   // ==================================================================
   // Three-stage synchronisers for the scan-side levels
   reg  [`DSA_SYNC_W-1:0]    sync1_r;
   reg  [`DSA_SYNC_W-1:0]    sync2_r;
   reg  [`DSA_SYNC_W-1:0]    sync3_r;
   reg  [`DSA_SYNC_W-1:0]    clean_r;
   wire [`DSA_SYNC_W-1:0]    raw_in;
   wire [`DSA_SYNC_W-1:0]    agree;
   reg                       sclk_d_r;
   reg                       idle_d_r;
   wire                      sclk_rise;
   wire                      shift_evt;
   wire                      capt_evt;
   wire                      idle_evt;

   assign raw_in = {TAP_BYPASS, TAP_RUN_IDLE, TAP_CAPTURE,
                    TAP_SHIFT, SCAN_DI, SCAN_CLK};
   assign agree  = ~(sync2_r ^ sync3_r);

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sync1_r  <= {`DSA_SYNC_W{1'b0}};
         sync2_r  <= {`DSA_SYNC_W{1'b0}};
         sync3_r  <= {`DSA_SYNC_W{1'b0}};
         clean_r  <= {`DSA_SYNC_W{1'b0}};
         sclk_d_r <= 1'b0;
         idle_d_r <= 1'b0;
      end else begin
         sync1_r  <= raw_in;
         sync2_r  <= sync1_r;
         sync3_r  <= sync2_r;
         // A lane changes only once stages two and three agree
         clean_r  <= (agree & sync3_r) | (~agree & clean_r);
         sclk_d_r <= clean_r[`DSA_LN_SCLK];
         idle_d_r <= clean_r[`DSA_LN_IDLE];
      end
   end

   assign sclk_rise = clean_r[`DSA_LN_SCLK] & ~sclk_d_r;
   assign shift_evt = sclk_rise & clean_r[`DSA_LN_SHIFT];
   assign capt_evt  = sclk_rise & clean_r[`DSA_LN_CAPT];
   // One core clock per entry into run-test/idle
   assign idle_evt  = clean_r[`DSA_LN_IDLE] & ~idle_d_r;

   // ==================================================================
   // Data-bus scan chain
   reg  [`DSA_CHAIN_LEN-1:0] chain_r;
   reg  [`DSA_CNT_W-1:0]     shift_cnt_r;
   reg                       cause_r;
   reg                       first_capt_r;
   reg  [2:0]                state_r;
   wire                      capt_flag;
   wire                      in_debug;
   wire                      step_ok;

   assign in_debug  = (state_r == ST_DEBUG);
   assign capt_flag = first_capt_r ? cause_r : BREAKPOINT_INPUT_BIT;
   assign step_ok   = in_debug & idle_evt & ~clean_r[`DSA_LN_BYP]
                      & (shift_cnt_r == `DSA_CNT_FULL);

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         chain_r     <= {`DSA_CHAIN_LEN{1'b0}};
         shift_cnt_r <= `DSA_CNT_ZERO;
         SCAN_DO     <= 1'b0;
      end else begin
         if (capt_evt) begin
            chain_r     <= {capt_flag, CORE_DATA};
            shift_cnt_r <= `DSA_CNT_ZERO;
         end else if (shift_evt) begin
            chain_r <= {chain_r[`DSA_CHAIN_LEN-2:0],
                        clean_r[`DSA_LN_DI]};
            if (shift_cnt_r != `DSA_CNT_FULL)
               shift_cnt_r <= shift_cnt_r + `DSA_CNT_ONE;
         end else if (step_ok) begin
            shift_cnt_r <= `DSA_CNT_ZERO;
         end
         SCAN_DO <= chain_r[`DSA_FLAG_BIT];
      end
   end

   // ==================================================================
   // Debug state sequencer
   reg                       prev_flag_r;
   reg                       armed_r;
   reg                       exit_r;
   wire                      is_branch;
   wire                      entry_hit;

   assign is_branch = (chain_r[`DSA_CLASS_HI:`DSA_CLASS_LO]
                       == `DSA_CLASS_BRANCH);
   assign entry_hit = BREAKPOINT_HIT | WATCHPOINT_HIT;

   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         state_r                 <= ST_RUN;
         cause_r                 <= 1'b0;
         first_capt_r            <= 1'b0;
         prev_flag_r             <= 1'b0;
         armed_r                 <= 1'b0;
         exit_r                  <= 1'b0;
         DEBUG_INSTR             <= {`DSA_DATA_W{1'b0}};
         SCAN_DERIVED_CORE_CLOCK <= 1'b0;
         SYS_SPEED_EXEC          <= 1'b0;
         PIPE_FLUSH              <= 1'b0;
         PC_ADVANCE              <= 1'b0;
         PC_ADVANCE_BYTES        <= `DSA_PC_NONE;
         MODE_CHANGE_ANY         <= 1'b0;
         CLOCK_SELECT_DEBUG      <= 1'b0;
         DEBUG_STATE_ACKNOWLEDGE <= 1'b0;
         MEMORY_REQUEST_N        <= 1'b1;
      end else begin
         SCAN_DERIVED_CORE_CLOCK <= 1'b0;
         SYS_SPEED_EXEC          <= 1'b0;
         PIPE_FLUSH              <= 1'b0;
         PC_ADVANCE              <= 1'b0;
         PC_ADVANCE_BYTES        <= `DSA_PC_NONE;
         if (capt_evt)
            first_capt_r <= 1'b0;
         MODE_CHANGE_ANY <= in_debug;
         case (state_r)
            ST_RUN: begin
               MEMORY_REQUEST_N <= CORE_MREQ_N;
               if (entry_hit) begin
                  DEBUG_STATE_ACKNOWLEDGE <= 1'b1;
                  cause_r          <= WATCHPOINT_HIT;
                  first_capt_r     <= 1'b1;
                  PIPE_FLUSH       <= 1'b1;
                  PC_ADVANCE       <= 1'b1;
                  PC_ADVANCE_BYTES <= `DSA_PC_ENTRY;
                  prev_flag_r      <= 1'b0;
                  armed_r          <= 1'b0;
                  state_r          <= ST_ENTER;
               end
            end
            ST_ENTER: begin
               // Final pre-debug access in the cycle after the rise
               MEMORY_REQUEST_N   <= CORE_MREQ_N;
               CLOCK_SELECT_DEBUG <= 1'b1;
               state_r            <= ST_DEBUG;
            end
            ST_DEBUG: begin
               MEMORY_REQUEST_N <= 1'b1;
               if (step_ok) begin
                  SCAN_DERIVED_CORE_CLOCK <= 1'b1;
                  DEBUG_INSTR      <= chain_r[`DSA_DATA_W-1:0];
                  PC_ADVANCE       <= 1'b1;
                  PC_ADVANCE_BYTES <= `DSA_PC_STEP;
                  armed_r          <= prev_flag_r;
                  prev_flag_r      <= chain_r[`DSA_FLAG_BIT];
                  exit_r           <= is_branch;
               end else if (armed_r & clean_r[`DSA_LN_BYP]) begin
                  armed_r            <= 1'b0;
                  CLOCK_SELECT_DEBUG <= 1'b0;
                  if (exit_r) begin
                     state_r <= ST_EXIT;
                  end else begin
                     DEBUG_STATE_ACKNOWLEDGE <= FORCE_ACK_HIGH;
                     state_r <= ST_RESYNC;
                  end
               end
            end
            ST_RESYNC: begin
               DEBUG_STATE_ACKNOWLEDGE <= FORCE_ACK_HIGH;
               MEMORY_REQUEST_N <= 1'b0;
               SYS_SPEED_EXEC   <= 1'b1;
               state_r          <= ST_SYSACC;
            end
            ST_SYSACC: begin
               DEBUG_STATE_ACKNOWLEDGE <= FORCE_ACK_HIGH;
               // Held here for as long as the bus is withheld
               if (MEM_GRANT) begin
                  MEMORY_REQUEST_N <= 1'b1;
                  state_r          <= ST_RETURN;
               end
            end
            ST_RETURN: begin
               DEBUG_STATE_ACKNOWLEDGE <= 1'b1;
               CLOCK_SELECT_DEBUG <= 1'b1;
               cause_r            <= 1'b1;
               first_capt_r       <= 1'b1;
               PC_ADVANCE         <= 1'b1;
               PC_ADVANCE_BYTES   <= `DSA_PC_SYSACC;
               prev_flag_r        <= 1'b0;
               state_r            <= ST_DEBUG;
            end
            ST_EXIT: begin
               // Request stays high in the cycle the acknowledge falls
               DEBUG_STATE_ACKNOWLEDGE <= 1'b0;
               MEMORY_REQUEST_N        <= 1'b1;
               state_r <= ST_RUN;
            end
            default: begin
               state_r <= ST_RUN;
            end
         endcase
         // First refetch in the cycle after the acknowledge falls
         if ((state_r == ST_RUN) && exit_r) begin
            MEMORY_REQUEST_N <= 1'b0;
            exit_r           <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ==== rtl/dsa_defines.vh ====
/*
 Constants for the debug state access and exit controller: scan chain
 geometry, PC advance figures and instruction decode fields.
 Assumes inclusion by its bare name from the design files only.
*/
`ifndef DSA_DEFINES_VH
`define DSA_DEFINES_VH

// =====================================================================
// Scan chain geometry
`define DSA_CHAIN_LEN      33
`define DSA_DATA_W         32
`define DSA_CNT_W          6
`define DSA_CNT_FULL       6'h21
`define DSA_CNT_ZERO       6'h00
`define DSA_CNT_ONE        6'h01
`define DSA_FLAG_BIT       32

// =====================================================================
// PC advance, in bytes
`define DSA_PC_W           5
`define DSA_PC_ENTRY       5'h10
`define DSA_PC_STEP        5'h04
`define DSA_PC_SYSACC      5'h0c
`define DSA_PC_NONE        5'h00

// =====================================================================
// Instruction decode: branch class in bits 27:25
`define DSA_CLASS_HI       27
`define DSA_CLASS_LO       25
`define DSA_CLASS_BRANCH   3'h5

// =====================================================================
// Synchroniser lanes
`define DSA_SYNC_W         6
`define DSA_LN_SCLK        0
`define DSA_LN_DI          1
`define DSA_LN_SHIFT       2
`define DSA_LN_CAPT        3
`define DSA_LN_IDLE        4
`define DSA_LN_BYP         5

`endif

// ==== dv/dsa_debug_ctrl_sva.sv ====
/* Checker for dsa_debug_ctrl: entry, step, system access and exit timing.
   Sees only the block's ports; one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dsa_debug_ctrl_sva (
   input wire logic       CLOCK,
   input wire logic       RST_B,
   input wire logic       FORCE_ACK_HIGH,
   input wire logic       CORE_MREQ_N,
   input wire logic       MEM_GRANT,
   input wire logic       SCAN_DERIVED_CORE_CLOCK,
   input wire logic       SYS_SPEED_EXEC,
   input wire logic       PIPE_FLUSH,
   input wire logic       PC_ADVANCE,
   input wire logic [4:0] PC_ADVANCE_BYTES,
   input wire logic       CLOCK_SELECT_DEBUG,
   input wire logic       DEBUG_STATE_ACKNOWLEDGE,
   input wire logic       MEMORY_REQUEST_N
);
   // ==========================================================
   // System access in flight until the request rises
   logic in_sys_r;
   always @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B)
         in_sys_r <= 1'b0;
      else if (SYS_SPEED_EXEC | MEMORY_REQUEST_N)
         in_sys_r <= SYS_SPEED_EXEC;
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   entry_order_a: assert property (
      $rose(DEBUG_STATE_ACKNOWLEDGE) && !CLOCK_SELECT_DEBUG |->
      (PIPE_FLUSH && PC_ADVANCE_BYTES == 5'h10) ##1 CLOCK_SELECT_DEBUG)
      else $error("entry order");
   last_access_a: assert property (
      $rose(DEBUG_STATE_ACKNOWLEDGE) && PIPE_FLUSH |=>
      (MEMORY_REQUEST_N == $past(CORE_MREQ_N)) ##1 MEMORY_REQUEST_N)
      else $error("last access");
   ack_in_debug_a: assert property (CLOCK_SELECT_DEBUG |->
      DEBUG_STATE_ACKNOWLEDGE) else $error("ack low on debug clock");
   step_pc_a: assert property (SCAN_DERIVED_CORE_CLOCK |-> PC_ADVANCE &&
      PC_ADVANCE_BYTES == 5'h04) else $error("step advance");
   sys_launch_a: assert property (SYS_SPEED_EXEC |-> !MEMORY_REQUEST_N &&
      !CLOCK_SELECT_DEBUG && $past(CLOCK_SELECT_DEBUG, 2))
      else $error("system launch");
   sys_ack_a: assert property (in_sys_r |->
      DEBUG_STATE_ACKNOWLEDGE == FORCE_ACK_HIGH) else $error("ack in access");
   req_hold_a: assert property (in_sys_r && !MEMORY_REQUEST_N &&
      !MEM_GRANT |=> !MEMORY_REQUEST_N) else $error("request dropped");
   sys_return_a: assert property (
      in_sys_r && !MEMORY_REQUEST_N && MEM_GRANT |=> MEMORY_REQUEST_N ##1
      (DEBUG_STATE_ACKNOWLEDGE && CLOCK_SELECT_DEBUG &&
      PC_ADVANCE_BYTES == 5'h0c)) else $error("system return");
   exit_fetch_a: assert property ($fell(DEBUG_STATE_ACKNOWLEDGE) &&
      !CLOCK_SELECT_DEBUG && !$fell(CLOCK_SELECT_DEBUG) |=> !MEMORY_REQUEST_N)
      else $error("exit fetch");
   cover property (SYS_SPEED_EXEC && FORCE_ACK_HIGH);
   cover property (SYS_SPEED_EXEC && !FORCE_ACK_HIGH);
   cover property ($fell(DEBUG_STATE_ACKNOWLEDGE));
endmodule
bind dsa_debug_ctrl dsa_debug_ctrl_sva u_sva (.*);
`default_nettype wire

// ==== dv/dsa_mem_model.sv ====
/* Memory controller model: grants the bus a set number of cycles
   after the request goes low. Shares the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module dsa_mem_model (
   input  wire logic       clk,
   input  wire logic       req_n,
   input  wire logic [7:0] wait_cyc,
   output var  logic       grant_r
);
   // ==========================================================
   // Grant after wait_cyc cycles, withheld until then
   logic [7:0] cnt_r = 8'h00;
   initial grant_r = 1'b0;
   always @(posedge clk) begin
      if (req_n) begin
         cnt_r <= 8'h00;
         grant_r <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         grant_r <= cnt_r >= wait_cyc;
      end
   end
endmodule
`default_nettype wire

// ==== dv/dsa_debug_ctrl_tb.sv ====
/* Testbench for dsa_debug_ctrl: entry, debug-speed steps, system access
   and exit. Assumes the memory model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module dsa_debug_ctrl_tb;
   logic        CLOCK = 1'b0, RST_B = 1'b0, SCAN_CLK = 1'b0;
   logic        SCAN_DI = 1'b0, TAP_SHIFT = 1'b0, TAP_CAPTURE = 1'b0;
   logic        TAP_RUN_IDLE = 1'b0, TAP_BYPASS = 1'b0, CORE_MREQ_N = 1'b0;
   logic        BREAKPOINT_HIT = 1'b0, WATCHPOINT_HIT = 1'b0;
   logic        BREAKPOINT_INPUT_BIT = 1'b1, FORCE_ACK_HIGH = 1'b0;
   logic [31:0] CORE_DATA = 32'h1234abcd;
   logic [7:0]  wait_cyc = 8'h05;
   wire logic   SCAN_DO, SCAN_DERIVED_CORE_CLOCK, SYS_SPEED_EXEC, PIPE_FLUSH;
   wire logic   PC_ADVANCE, MODE_CHANGE_ANY, CLOCK_SELECT_DEBUG, MEM_GRANT;
   wire logic   DEBUG_STATE_ACKNOWLEDGE, MEMORY_REQUEST_N;
   wire logic [31:0] DEBUG_INSTR;
   wire logic [4:0]  PC_ADVANCE_BYTES;
   wire logic [4:0]  ev = {!DEBUG_STATE_ACKNOWLEDGE, CLOCK_SELECT_DEBUG &
      MEMORY_REQUEST_N & DEBUG_STATE_ACKNOWLEDGE, SYS_SPEED_EXEC,
      SCAN_DERIVED_CORE_CLOCK, DEBUG_STATE_ACKNOWLEDGE};
   int          mismatches = 0, n_checks = 0;

   dsa_debug_ctrl uut (.*);
   dsa_mem_model mem (.clk(CLOCK), .req_n(MEMORY_REQUEST_N),
      .wait_cyc(wait_cyc), .grant_r(MEM_GRANT));

   initial forever #5 CLOCK = ~CLOCK;

   // ==========================================================
   // Shared tasks
   task chk(input string what, input logic [39:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge CLOCK);
   endtask
   task waitsig(input int k);
      int i;
      for (i = 0; i < 400 && ev[k] !== 1'b1; i++)
         cyc(1);
      if (i == 400) begin
         mismatches++;
         $display("Error wait %0d expected 1 seen 0", k);
         end_of_test;
      end
   endtask
   task sclk;
      SCAN_CLK = 1'b1;
      cyc(8);
      SCAN_CLK = 1'b0;
      cyc(8);
   endtask

   // ==========================================================
   // Scenarios
   task entry(input logic wp);
      BREAKPOINT_HIT = !wp;
      WATCHPOINT_HIT = wp;
      cyc(1);
      BREAKPOINT_HIT = 1'b0;
      WATCHPOINT_HIT = 1'b0;
      waitsig(0);
      chk("entry", {PIPE_FLUSH, PC_ADVANCE, PC_ADVANCE_BYTES}, 7'h70);
      cyc(1);
      chk("switch", {CLOCK_SELECT_DEBUG, MEMORY_REQUEST_N}, 2'b10);
      cyc(1);
      chk("in debug", {MEMORY_REQUEST_N, MODE_CHANGE_ANY}, 2'b11);
   endtask
   task frame(input logic [32:0] word, input logic flag);
      logic [32:0] got;
      TAP_CAPTURE = 1'b1;
      sclk;
      TAP_CAPTURE = 1'b0;
      TAP_SHIFT = 1'b1;
      for (int i = 32; i >= 0; i--) begin
         got[i] = SCAN_DO;
         SCAN_DI = word[i];
         sclk;
      end
      TAP_SHIFT = 1'b0;
      chk("scan out", {flag, CORE_DATA}, got);
      TAP_RUN_IDLE = 1'b1;
      waitsig(1);
      chk("step", {word[31:0], 5'h04}, {DEBUG_INSTR, PC_ADVANCE_BYTES});
      cyc(1);
      TAP_RUN_IDLE = 1'b0;
      CORE_DATA = ~CORE_DATA;
      cyc(2);
   endtask
   task sysacc(input logic frc, input logic [7:0] w);
      FORCE_ACK_HIGH = frc;
      wait_cyc = w;
      TAP_BYPASS = 1'b1;
      waitsig(2);
      chk("sys start", {DEBUG_STATE_ACKNOWLEDGE, CLOCK_SELECT_DEBUG,
         MEMORY_REQUEST_N}, {frc, 2'b00});
      waitsig(3);
      chk("sys end", {PC_ADVANCE, PC_ADVANCE_BYTES}, 6'h2c);
      TAP_BYPASS = 1'b0;
      cyc(2);
   endtask
   task leave;
      // Core idle, so the refetch request must come from the exit itself
      CORE_MREQ_N = 1'b1;
      TAP_BYPASS = 1'b1;
      waitsig(4);
      chk("exit", {CLOCK_SELECT_DEBUG, MEMORY_REQUEST_N, MODE_CHANGE_ANY},
         3'b010);
      cyc(1);
      chk("refetch", MEMORY_REQUEST_N, 1'b0);
      TAP_BYPASS = 1'b0;
      cyc(2);
      CORE_MREQ_N = 1'b0;
   endtask

   initial begin
      cyc(2);
      RST_B = 1'b1;
      cyc(6);
      entry(1'b0);
      frame({1'b0, 32'he0802000}, 1'b0);
      frame({1'b1, 32'he5901000}, 1'b1);
      frame({1'b0, 32'he5912000}, 1'b1);
      sysacc(1'b0, 8'h05);
      BREAKPOINT_INPUT_BIT = 1'b0;
      frame({1'b1, 32'he5812000}, 1'b1);
      frame({1'b0, 32'he5812000}, 1'b0);
      sysacc(1'b1, 8'h00);
      frame({1'b1, 32'he1a00000}, 1'b1);
      frame({1'b0, 32'heafffff1}, 1'b0);
      leave;
      entry(1'b1);
      frame({1'b0, 32'he1a00000}, 1'b1);
      end_of_test;
   end
endmodule
`default_nettype wire
